// ---- hltmr_top.sv ----
// Period timer with hardware limit, AHB-Lite register slave
//
// Contract
// - Count and period registers, software read/write
// - Count increments on each prescaler output tick
// - Prescaler ratio programmable 1:1 to 1:128
// - Postscaler 1:1 to 1:16 counts matches
// - Match pulse to postscaler, count clears on the same tick
// - Free-running: match zeroes count, advances postscaler
// - Postscaler match: one timer-clock pulse, clear
// - Gate modes halt while gate inactive
// - Reset modes clear count on level/edge
// - Reset clears count, period becomes FF
// - Pre/postscaler clear on count/control writes, resets, events
// - Control write leaves count unchanged
// - One-shot match clears on bit, stops
// - One-shot ignores nonzero postscale select
// - Monostable edge-start modes keep on bit, external restart
// - Reset source selectable, starts/stops/resets timer
// - Interrupt on postscaler match, gated by enable
// - Flag set within two cycles, software clears
// - Prescaler sync resynchronises tick to system clock
// - Enable sync aligns on bit to timer clock
// - Without enable sync, on bit acts immediately
// - One-shot stops with count held at zero
// - Debug mode ignores external trigger inputs
`timescale 1ns/1ps
module hltmr_top
   import hltmr_pkg::*;
#(
   parameter int NUM_RST_SRC = 16
) (
   input  wire logic                   CLK_SYS_I,
   input  wire logic                   NRST_I,
   input  wire logic                   HSEL_I,
   input  wire logic [31:0]            HADDR_I,
   input  wire logic [1:0]             HTRANS_I,
   input  wire logic                   HWRITE_I,
   input  wire logic [2:0]             HSIZE_I,
   input  wire logic [31:0]            HWDATA_I,
   input  wire logic                   HREADY_I,
   output logic      [31:0]            HRDATA_O,
   output logic                        HREADYOUT_O,
   output logic                        HRESP_O,
   input  wire logic                   TMR_CLK_I,
   input  wire logic [NUM_RST_SRC-1:0] EXT_RST_I,
   input  wire logic                   DEBUG_I,
   output logic                        POSTSCALED_O,
   output logic                        IRQ_O
);
   initial begin
      if (NUM_RST_SRC < 1 || NUM_RST_SRC > 16) begin
         $error("NUM_RST_SRC must lie in 1..16");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0]         cnt_r, cnt_nxt, per_r, per_nxt;
   logic               on_r, on_nxt, on_eff_r, on_eff_nxt;
   logic [2:0]         pre_sel_r, pre_sel_nxt;
   logic [3:0]         post_sel_r, post_sel_nxt;
   logic               pre_sync_r, pre_sync_nxt, en_sync_r, en_sync_nxt;
   logic [4:0]         mode_r, mode_nxt;
   logic [3:0]         rst_src_r, rst_src_nxt;
   logic               flag_r, flag_nxt, irq_en_r, irq_en_nxt;
   logic [PRE_W-1:0]   pre_cnt_r, pre_cnt_nxt;
   logic [3:0]         post_cnt_r, post_cnt_nxt;
   hltmr_state_t       st_r, st_nxt;
   logic               clk_q_r, ers_q_r, tick_d_r, post_req_r, pulse_r, pulse_nxt;
   logic               irq_nxt;
   logic               wr_pend_r, wr_pend_nxt;
   logic [ADDR_W-1:0]  addr_r, addr_nxt;
   logic [31:0]        rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic               acc, cnt_wr, ctl_wr;
   logic [31:0]        rd_mux;
   always_comb begin
      acc         = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ);
      wr_pend_nxt = acc && HWRITE_I;
      addr_nxt    = acc ? HADDR_I[ADDR_W-1:0] : addr_r;
      cnt_wr      = wr_pend_r && (addr_r == OFS_COUNT);
      ctl_wr      = wr_pend_r && (addr_r == OFS_CONTROL);
      if (HADDR_I[ADDR_W-1:0] == OFS_CONTROL) begin
         rd_mux = {24'h000000, on_r, pre_sel_r, post_sel_r};
      end else if (HADDR_I[ADDR_W-1:0] == OFS_COUNT) begin
         rd_mux = {24'h000000, cnt_r};
      end else if (HADDR_I[ADDR_W-1:0] == OFS_PERIOD) begin
         rd_mux = {24'h000000, per_r};
      end else if (HADDR_I[ADDR_W-1:0] == OFS_HLTCTL) begin
         rd_mux = {24'h000000, pre_sync_r, en_sync_r, 1'b0, mode_r};
      end else if (HADDR_I[ADDR_W-1:0] == OFS_RSTSEL) begin
         rd_mux = {28'h0000000, rst_src_r};
      end else if (HADDR_I[ADDR_W-1:0] == OFS_IRQ) begin
         rd_mux = {30'h00000000, irq_en_r, flag_r};
      end else begin
         rd_mux = 32'h00000000;
      end
      rdata_nxt = (acc && !HWRITE_I) ? rd_mux : HRDATA_O;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger and mode decode
   logic [1:0]  fam;
   logic [2:0]  sub;
   logic        ers_now, ers, rise, fall, anye, clk_edge;
   logic        start, gate, hw_rst, stop_at_match, clear_on;
   always_comb begin
      fam      = mode_r[4:3];
      sub      = mode_r[2:0];
      ers_now  = (32'(rst_src_r) < NUM_RST_SRC) ? EXT_RST_I[rst_src_r] : 1'b0;
      ers      = DEBUG_I ? ers_q_r : ers_now;
      rise     = ers && !ers_q_r;
      fall     = !ers && ers_q_r;
      anye     = rise || fall;
      clk_edge = TMR_CLK_I && !clk_q_r;
      start         = 1'b0;
      gate          = 1'b1;
      hw_rst        = 1'b0;
      stop_at_match = (fam != FAM_FREE);
      clear_on      = (fam == FAM_ONESHOT) ||
                      ((fam == FAM_MONO) && (sub == SUB_LVL_HI || sub == SUB_LVL_LO));
      case (fam)
         FAM_FREE: begin
            start = 1'b1;
            case (sub)
               SUB_GATE_HI:  gate   = ers;
               SUB_GATE_LO:  gate   = !ers;
               SUB_RST_ANY:  hw_rst = anye;
               SUB_RST_RISE: hw_rst = rise;
               SUB_RST_FALL: hw_rst = fall;
               SUB_RST_LOW:  hw_rst = !ers;
               SUB_RST_HIGH: hw_rst = ers;
               default:      gate   = 1'b1;
            endcase
         end
         FAM_ONESHOT: begin
            case (sub)
               SUB_SW:        start = 1'b1;
               SUB_ST_RISE:   start = rise;
               SUB_ST_FALL:   start = fall;
               SUB_ST_ANY:    start = anye;
               SUB_RR_RISE: begin
                  start  = rise;
                  hw_rst = rise;
               end
               SUB_FR_FALL: begin
                  start  = fall;
                  hw_rst = fall;
               end
               SUB_RISE_LRST: begin
                  start  = rise;
                  hw_rst = !ers;
               end
               default: begin
                  start  = fall;
                  hw_rst = ers;
               end
            endcase
         end
         FAM_MONO: begin
            case (sub)
               SUB_ST_RISE: start = rise;
               SUB_ST_FALL: start = fall;
               SUB_ST_ANY:  start = anye;
               SUB_LVL_HI: begin
                  start  = ers;
                  hw_rst = !ers;
               end
               SUB_LVL_LO: begin
                  start  = !ers;
                  hw_rst = ers;
               end
               default:     start = 1'b0;
            endcase
         end
         default: start = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler, counter, postscaler
   logic [7:0]  pre_span;
   logic        active, tick_raw, tick, count_tick, match_ev, post_ev;
   logic [3:0]  sel_eff;
   always_comb begin
      pre_span   = (8'h01 << pre_sel_r) - 8'h01;
      active     = (st_r == ST_RUN) && on_eff_r && gate && !hw_rst;
      tick_raw   = clk_edge && active &&
                   ((pre_cnt_r & pre_span[PRE_W-1:0]) == pre_span[PRE_W-1:0]);
      tick       = pre_sync_r ? tick_d_r : tick_raw;
      count_tick = tick && active;
      match_ev   = count_tick && (cnt_r == per_r);
      sel_eff    = (fam == FAM_ONESHOT) ? 4'h0 : post_sel_r;
      post_ev    = match_ev && (post_cnt_r == sel_eff);
      // Enable sync: the on bit takes effect at a timer clock edge, that edge uncounted
      on_eff_nxt = en_sync_r ? (clk_edge ? on_r : on_eff_r) : on_r;
      cnt_nxt      = cnt_r;
      pre_cnt_nxt  = pre_cnt_r;
      post_cnt_nxt = post_cnt_r;
      st_nxt       = st_r;
      on_nxt       = on_r;
      if (clk_edge && active) begin
         pre_cnt_nxt = pre_cnt_r + 7'h01;
      end
      case (st_r)
         ST_WAIT: begin
            if (on_eff_r && on_r && start) begin
               st_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!on_eff_r) begin
               st_nxt = ST_WAIT;
            end else if (match_ev && stop_at_match) begin
               st_nxt = ST_WAIT;
            end
         end
         default: st_nxt = ST_WAIT;
      endcase
      if (count_tick) begin
         cnt_nxt = match_ev ? COUNT_RST : cnt_r + 8'h01;
      end
      if (match_ev) begin
         post_cnt_nxt = post_ev ? 4'h0 : post_cnt_r + 4'h1;
         if (clear_on) begin
            on_nxt = 1'b0;
         end
      end
      if (hw_rst) begin
         cnt_nxt      = COUNT_RST;
         pre_cnt_nxt  = '0;
         post_cnt_nxt = 4'h0;
      end
      if (cnt_wr || ctl_wr) begin
         pre_cnt_nxt  = '0;
         post_cnt_nxt = 4'h0;
      end
      if (cnt_wr) begin
         cnt_nxt = HWDATA_I[7:0];
      end
      if (ctl_wr) begin
         on_nxt = HWDATA_I[CTL_ON_BIT];
      end
      if (post_ev) begin
         pulse_nxt = 1'b1;
      end else if (clk_edge) begin
         pulse_nxt = 1'b0;
      end else begin
         pulse_nxt = pulse_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software fields and interrupt flag
   always_comb begin
      per_nxt      = per_r;
      pre_sel_nxt  = pre_sel_r;
      post_sel_nxt = post_sel_r;
      pre_sync_nxt = pre_sync_r;
      en_sync_nxt  = en_sync_r;
      mode_nxt     = mode_r;
      rst_src_nxt  = rst_src_r;
      irq_en_nxt   = irq_en_r;
      flag_nxt     = flag_r;
      if (ctl_wr) begin
         pre_sel_nxt  = HWDATA_I[CTL_PRE_LSB +: 3];
         post_sel_nxt = HWDATA_I[CTL_POST_LSB +: 4];
      end
      if (wr_pend_r && addr_r == OFS_PERIOD) begin
         per_nxt = HWDATA_I[7:0];
      end
      if (wr_pend_r && addr_r == OFS_HLTCTL) begin
         pre_sync_nxt = HWDATA_I[LIM_PRE_SYNC_BIT];
         en_sync_nxt  = HWDATA_I[LIM_EN_SYNC_BIT];
         mode_nxt     = HWDATA_I[LIM_MODE_LSB +: 5];
      end
      if (wr_pend_r && addr_r == OFS_RSTSEL) begin
         rst_src_nxt = HWDATA_I[3:0];
      end
      if (wr_pend_r && addr_r == OFS_IRQ) begin
         irq_en_nxt = HWDATA_I[IRQ_EN_BIT];
         if (HWDATA_I[IRQ_FLAG_BIT]) begin
            flag_nxt = 1'b0;
         end
      end
      if (post_req_r) begin
         flag_nxt = 1'b1;
      end
      irq_nxt = flag_r && irq_en_r;
   end

   always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cnt_r        <= COUNT_RST;
         per_r        <= PERIOD_RST;
         on_r         <= 1'b0;
         on_eff_r     <= 1'b0;
         pre_sel_r    <= 3'h0;
         post_sel_r   <= 4'h0;
         pre_sync_r   <= 1'b0;
         en_sync_r    <= 1'b0;
         mode_r       <= 5'h00;
         rst_src_r    <= 4'h0;
         flag_r       <= 1'b0;
         irq_en_r     <= 1'b0;
         pre_cnt_r    <= '0;
         post_cnt_r   <= 4'h0;
         st_r         <= ST_WAIT;
         clk_q_r      <= 1'b0;
         ers_q_r      <= 1'b0;
         tick_d_r     <= 1'b0;
         post_req_r   <= 1'b0;
         pulse_r      <= 1'b0;
         wr_pend_r    <= 1'b0;
         addr_r       <= '0;
         HRDATA_O     <= 32'h00000000;
         HREADYOUT_O  <= 1'b1;
         HRESP_O      <= HRESP_OKAY;
         POSTSCALED_O <= 1'b0;
         IRQ_O        <= 1'b0;
      end else begin
         cnt_r        <= cnt_nxt;
         per_r        <= per_nxt;
         on_r         <= on_nxt;
         on_eff_r     <= on_eff_nxt;
         pre_sel_r    <= pre_sel_nxt;
         post_sel_r   <= post_sel_nxt;
         pre_sync_r   <= pre_sync_nxt;
         en_sync_r    <= en_sync_nxt;
         mode_r       <= mode_nxt;
         rst_src_r    <= rst_src_nxt;
         flag_r       <= flag_nxt;
         irq_en_r     <= irq_en_nxt;
         pre_cnt_r    <= pre_cnt_nxt;
         post_cnt_r   <= post_cnt_nxt;
         st_r         <= st_nxt;
         clk_q_r      <= TMR_CLK_I;
         ers_q_r      <= ers;
         tick_d_r     <= tick_raw;
         post_req_r   <= post_ev;
         pulse_r      <= pulse_nxt;
         wr_pend_r    <= wr_pend_nxt;
         addr_r       <= addr_nxt;
         HRDATA_O     <= rdata_nxt;
         HREADYOUT_O  <= 1'b1;
         HRESP_O      <= HRESP_OKAY;
         POSTSCALED_O <= pulse_nxt;
         IRQ_O        <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);

   chk_count_step: assert property (
      count_tick && !match_ev && !cnt_wr && !hw_rst |=> cnt_r == $past(cnt_r) + 8'h01)
      else $error("Count did not step on tick");
   chk_match_clear: assert property (
      match_ev && !cnt_wr |=> cnt_r == COUNT_RST)
      else $error("Count not cleared after match");
   chk_post_pulse: assert property (
      post_ev |=> POSTSCALED_O && post_cnt_r == 4'h0 && pulse_r)
      else $error("Postscaled pulse missing");
   chk_gate_hold: assert property (
      fam == FAM_FREE && sub == SUB_GATE_HI && !ers && !cnt_wr |=> $stable(cnt_r))
      else $error("Count moved with gate closed");
   chk_hw_reset: assert property (
      hw_rst && !cnt_wr |=> cnt_r == COUNT_RST && pre_cnt_r == '0)
      else $error("External reset did not clear count");
   chk_ctl_keeps: assert property (
      ctl_wr && !count_tick && !hw_rst |=> $stable(cnt_r) && post_cnt_r == 4'h0)
      else $error("Control write disturbed count");
   chk_oneshot_stop: assert property (
      match_ev && fam == FAM_ONESHOT && !ctl_wr |=> !on_r && st_r == ST_WAIT)
      else $error("One-shot did not stop");
   chk_oneshot_post: assert property (
      match_ev && fam == FAM_ONESHOT |-> post_ev)
      else $error("One-shot postscale not ignored");
   chk_mono_on: assert property (
      match_ev && fam == FAM_MONO && sub == SUB_ST_RISE && !ctl_wr |=> on_r)
      else $error("Monostable cleared on bit");
   chk_irq_flag: assert property (
      post_ev |-> ##2 flag_r ##1 (IRQ_O == irq_en_r || $changed(irq_en_r)))
      else $error("Interrupt flag late");
   chk_debug_quiet: assert property (
      DEBUG_I |-> !rise && !fall)
      else $error("Trigger seen in debug");

   cov_oneshot_done: cover property (match_ev && fam == FAM_ONESHOT);
   cov_post_match:   cover property (post_ev && post_sel_r == 4'h3);
   cov_edge_reset:   cover property (hw_rst && fam == FAM_FREE && sub == SUB_RST_RISE);
endmodule

// ---- hltmr_pkg.sv ----
// Constants, register map and state type of the period timer with hardware limit
package hltmr_pkg;
   localparam logic [7:0]  OFS_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_COUNT     = 8'h04;
   localparam logic [7:0]  OFS_PERIOD    = 8'h08;
   localparam logic [7:0]  OFS_HLTCTL    = 8'h0c;
   localparam logic [7:0]  OFS_RSTSEL    = 8'h10;
   localparam logic [7:0]  OFS_IRQ       = 8'h14;
   localparam int          ADDR_W        = 8;
   localparam int          CTL_ON_BIT    = 7;
   localparam int          CTL_PRE_LSB   = 4;
   localparam int          CTL_POST_LSB  = 0;
   localparam int          LIM_PRE_SYNC_BIT = 7;
   localparam int          LIM_EN_SYNC_BIT  = 6;
   localparam int          LIM_MODE_LSB     = 0;
   localparam int          IRQ_FLAG_BIT  = 0;
   localparam int          IRQ_EN_BIT    = 1;
   localparam int          PRE_W         = 7;
   localparam logic [7:0]  COUNT_RST     = 8'h00;
   localparam logic [7:0]  PERIOD_RST    = 8'hff;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
   localparam logic        HRESP_OKAY    = 1'b0;
   localparam logic [1:0]  FAM_FREE      = 2'b00;
   localparam logic [1:0]  FAM_ONESHOT   = 2'b01;
   localparam logic [1:0]  FAM_MONO      = 2'b10;
   localparam logic [2:0]  SUB_SW        = 3'h0;
   localparam logic [2:0]  SUB_GATE_HI   = 3'h1;
   localparam logic [2:0]  SUB_GATE_LO   = 3'h2;
   localparam logic [2:0]  SUB_RST_ANY   = 3'h3;
   localparam logic [2:0]  SUB_RST_RISE  = 3'h4;
   localparam logic [2:0]  SUB_RST_FALL  = 3'h5;
   localparam logic [2:0]  SUB_RST_LOW   = 3'h6;
   localparam logic [2:0]  SUB_RST_HIGH  = 3'h7;
   localparam logic [2:0]  SUB_ST_RISE   = 3'h1;
   localparam logic [2:0]  SUB_ST_FALL   = 3'h2;
   localparam logic [2:0]  SUB_ST_ANY    = 3'h3;
   localparam logic [2:0]  SUB_RR_RISE   = 3'h4;
   localparam logic [2:0]  SUB_FR_FALL   = 3'h5;
   localparam logic [2:0]  SUB_RISE_LRST = 3'h6;
   localparam logic [2:0]  SUB_FALL_HRST = 3'h7;
   localparam logic [2:0]  SUB_LVL_HI    = 3'h6;
   localparam logic [2:0]  SUB_LVL_LO    = 3'h7;
   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } hltmr_state_t;
endpackage

// ---- hltmr_far_model.sv ----
// Far-side model: timer input clock bursts and external reset sources
`timescale 1ns/1ps
module hltmr_far_model
#(
   parameter int NUM_SRC = 16
) (
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic               lvl_i,
   output logic                    tmr_clk_o,
   output logic [NUM_SRC-1:0]      ext_o
);
   logic tog_r;

   initial tmr_clk_o = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Unselected sources change every cycle so that a wrong selection shows
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tog_r <= 1'b0;
         ext_o <= '0;
      end else begin
         tog_r <= ~tog_r;
         for (int k = 0; k < NUM_SRC; k++) begin
            ext_o[k] <= (k == int'(sel_i)) ? lvl_i : tog_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer clock stands low between bursts; half period of two or more cycles
   task automatic burst(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge clk_i);
         tmr_clk_o <= 1'b1;
         repeat (half) @(posedge clk_i);
         tmr_clk_o <= 1'b0;
      end
   endtask
endmodule

// ---- hltmr_tb.sv ----
// Self-checking testbench of the period timer with hardware limit
`timescale 1ns/1ps
module tb
   import hltmr_pkg::*;
;
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
   logic        clk    = 1'b0;
   logic        nrst   = 1'b0;
   logic        hsel   = 1'b0;
   logic [31:0] haddr  = '0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic        debug  = 1'b0;
   logic        lvl    = 1'b0;
   logic [3:0]  sel    = 4'h0;
   logic        post_q = 1'b0;
   wire  [31:0] hrdata;
   wire         hready;
   wire         hresp;
   wire         tmr_clk;
   wire         post;
   wire         irq;
   wire  [15:0] ext;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          pulses      = 0;
   int          seed        = 71151;

   always #4 clk = ~clk;

   hltmr_top #(.NUM_RST_SRC(16)) dut (.CLK_SYS_I(clk), .NRST_I(nrst), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .TMR_CLK_I(tmr_clk), .EXT_RST_I(ext), .DEBUG_I(debug),
      .POSTSCALED_O(post), .IRQ_O(irq));

   hltmr_far_model #(.NUM_SRC(16)) far (.clk_i(clk), .nrst_i(nrst), .sel_i(sel),
      .lvl_i(lvl), .tmr_clk_o(tmr_clk), .ext_o(ext));

   always @(posedge clk) begin
      post_q <= post;
      if (post === 1'b1 && post_q === 1'b0) pulses++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 40);
      if (hready !== 1'b1) begin
         miscompares++;
         final_report();
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= 1'b1;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= 1'b0;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      wait_rdy();
      `CHK(nm, ex, hrdata)
      `CHK("response", HRESP_OKAY, hresp)
   endtask

   task automatic setup(input logic [7:0] p, input logic [7:0] hardware_limit_timer, input logic [7:0] ctl);
      bus_wr(OFS_CONTROL, 32'h0);
      bus_wr(OFS_COUNT, 32'h0);
      bus_wr(OFS_PERIOD, {24'h0, p});
      bus_wr(OFS_HLTCTL, {24'h0, hardware_limit_timer});
      bus_wr(OFS_RSTSEL, {28'h0, sel});
      bus_wr(OFS_CONTROL, {24'h0, ctl});
      pulses = 0;
   endtask

   task automatic trig(input logic v);
      lvl <= v;
      repeat (48) @(posedge clk);
   endtask

   function automatic logic [7:0] exp_cnt(input int n, input int pre, input int p);
      return 8'((n >> pre) % (p + 1));
   endfunction

   function automatic int exp_pls(input int n, input int pre, input int p, input int s);
      return ((n >> pre) / (p + 1)) / (s + 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int   p;
      int   s;
      int   n;
      int   h;
      logic en;
      logic f;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_chk(OFS_COUNT, {24'h0, COUNT_RST}, "count reset");
      rd_chk(OFS_PERIOD, {24'h0, PERIOD_RST}, "period reset");
      sel <= 4'($random(seed));
      n = $random(seed);
      bus_wr(OFS_COUNT, n);
      bus_wr(OFS_PERIOD, {n[7:0], n[31:8]});
      bus_wr(8'h18, 32'hffff_ffff);
      rd_chk(OFS_COUNT, {24'h0, n[7:0]}, "count rw");
      rd_chk(OFS_PERIOD, {24'h0, n[15:8]}, "period rw");
      rd_chk(8'h18, 32'h0, "unmapped");
      for (int pre = 0; pre < 8; pre++) begin
         p = 1 + (($random(seed) & 7) % 7);
         s = $random(seed) & 15;
         n = ((3 + ($random(seed) & 15)) << pre) + ($random(seed) & ((1 << pre) - 1));
         h = 2 + ($random(seed) & 3);
         en = pre[0];
         f = exp_pls(n, pre, p, s) > 0;
         bus_wr(OFS_IRQ, {30'h0, en, 1'b1});
         setup(8'(p), {$random(seed) % 2 == 0, 7'h0}, {1'b1, 3'(pre), 4'(s)});
         far.burst(n, h);
         bus_wr(OFS_CONTROL, 32'h0);
         rd_chk(OFS_COUNT, {24'h0, exp_cnt(n, pre, p)}, "count");
         `CHK("pulses", exp_pls(n, pre, p, s), pulses)
         rd_chk(OFS_IRQ, {30'h0, en, f}, "irq reg");
         `CHK("irq out", en & f, irq)
         bus_wr(OFS_IRQ, {30'h0, en, 1'b1});
         repeat (3) @(posedge clk);
         `CHK("irq cleared", 1'b0, irq)
      end
      setup(8'hff, 8'h40, 8'h80);
      far.burst(5, 3);
      rd_chk(OFS_COUNT, 32'h4, "enable sync");
      setup(8'hff, 8'h00, 8'h90);
      far.burst(1, 2);
      bus_wr(OFS_COUNT, 32'h0);
      far.burst(1, 2);
      rd_chk(OFS_COUNT, 32'h0, "count write");
      far.burst(1, 2);
      rd_chk(OFS_COUNT, 32'h1, "count write");
      setup(8'h03, {3'h0, FAM_ONESHOT, SUB_SW}, 8'h85);
      far.burst(10, 3);
      rd_chk(OFS_COUNT, 32'h0, "one shot count");
      rd_chk(OFS_CONTROL, 32'h05, "one shot on");
      `CHK("one shot pulses", 1, pulses)
      bus_wr(OFS_CONTROL, 32'h0);
      bus_wr(OFS_CONTROL, 32'h85);
      far.burst(2, 3);
      rd_chk(OFS_COUNT, 32'h2, "one shot again");
      trig(1'b0);
      setup(8'hff, {3'h0, FAM_FREE, SUB_GATE_HI}, 8'h80);
      far.burst(4, 2);
      rd_chk(OFS_COUNT, 32'h0, "gate off");
      trig(1'b1);
      far.burst(4, 2);
      rd_chk(OFS_COUNT, 32'h4, "gate on");
      trig(1'b0);
      setup(8'hff, {3'h0, FAM_FREE, SUB_RST_RISE}, 8'h80);
      far.burst(5, 2);
      debug <= 1'b1;
      trig(1'b1);
      trig(1'b0);
      rd_chk(OFS_COUNT, 32'h5, "debug");
      debug <= 1'b0;
      trig(1'b1);
      rd_chk(OFS_COUNT, 32'h0, "edge reset");
      setup(8'hff, {3'h0, FAM_FREE, SUB_RST_HIGH}, 8'h80);
      far.burst(3, 2);
      rd_chk(OFS_COUNT, 32'h0, "level reset");
      trig(1'b0);
      far.burst(3, 2);
      rd_chk(OFS_COUNT, 32'h3, "level release");
      setup(8'h03, {3'h0, FAM_MONO, SUB_ST_RISE}, 8'h80);
      far.burst(2, 2);
      rd_chk(OFS_COUNT, 32'h0, "mono wait");
      trig(1'b1);
      far.burst(10, 2);
      rd_chk(OFS_COUNT, 32'h0, "mono stop");
      rd_chk(OFS_CONTROL, 32'h80, "mono on");
      trig(1'b0);
      trig(1'b1);
      far.burst(2, 2);
      rd_chk(OFS_COUNT, 32'h2, "mono restart");
      setup(8'h03, {1'b0, 1'b1, 1'b0, FAM_ONESHOT, SUB_SW}, 8'h80);
      far.burst(10, 3);
      rd_chk(OFS_COUNT, 32'h0, "synced one shot");
      rd_chk(OFS_CONTROL, 32'h0, "synced one shot on");
      setup(8'hff, {3'h0, FAM_FREE, SUB_GATE_LO}, 8'h80);
      far.burst(3, 2);
      rd_chk(OFS_COUNT, 32'h0, "gate low off");
      trig(1'b0);
      far.burst(3, 2);
      rd_chk(OFS_COUNT, 32'h3, "gate low on");
      final_report();
   end
endmodule
